//--- interval_timer.sv
package supervisor_pkg;

  // Timebase and interval figures
  localparam int unsigned CLK_KHZ        = 200000;
  localparam int unsigned HOLD_TIME_MS   = 350;
  localparam int unsigned HOLD_MIN_MS    = 250;
  localparam int unsigned HOLD_MAX_MS    = 450;
  localparam int          CNT_W          = 27;
  localparam logic [CNT_W-1:0] HOLD_CYCLES =
    CNT_W'(HOLD_TIME_MS * CLK_KHZ);
  localparam logic [CNT_W-1:0] CNT_ONE   = 27'h0000001;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 27'h0000000;

  // Supply trip grades, percent below nominal
  typedef enum logic [1:0] {
    GRADE_5PCT,
    GRADE_10PCT,
    GRADE_15PCT
  } trip_grade_t;
  localparam int GRADE_CNT = 3;

  // Idle levels of the synchronisers at reset
  localparam logic LINE_IDLE   = 1'b1;
  localparam logic [GRADE_CNT-1:0] FAIL_IDLE = 3'h7;

endpackage

`timescale 1ns/100ps

module interval_timer
  import supervisor_pkg::*;
#(
  parameter logic [CNT_W-1:0] TERM_COUNT = HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // Control
  input  wire logic start_in,
  // Status
  output logic      done_out
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic             run_reg;
  logic             run_next;
  logic             done_reg;
  logic             done_next;

  // A start always restarts, so a stale run can never end a new interval
  always_comb begin
    count_next = count_reg;
    run_next   = run_reg;
    done_next  = 1'b0;
    if (start_in) begin
      count_next = CNT_ZERO;
      run_next   = 1'b1;
    end else if (run_reg) begin
      if (count_reg == TERM_COUNT - CNT_ONE) begin
        run_next  = 1'b0;
        done_next = 1'b1;
      end else begin
        count_next = count_reg + CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_reg <= CNT_ZERO;
      run_reg   <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      run_reg   <= run_next;
      done_reg  <= done_next;
    end
  end

  assign done_out = done_reg;

endmodule

//--- reset_supervisor.sv
// Functional notes
// - Supply fail drives reset line low
// - Hold reset 350 ms after supply recovers
// - Idle: watch shared line for falling edge
// - On button edge, pull low, debounce
// - After debounce, wait for release edge
// - On release, pulse low 350 ms
// - One shared wire: drive low only
// - Trip grade 5, 10 or 15 percent

`timescale 1ns/100ps

module reset_supervisor
  import supervisor_pkg::*;
#(
  parameter logic [CNT_W-1:0] HOLD_CYCLES_P  = HOLD_CYCLES,
  parameter trip_grade_t      SUPPLY_TRIP_THRESHOLD = GRADE_10PCT
) (
  // Clock and reset
  input  wire logic                 CLK_IN,
  input  wire logic                 NRST_IN,
  // Supply comparators, one per trip grade, high when below threshold
  input  wire logic [GRADE_CNT-1:0] SUPPLY_FAIL_IN,
  // Shared reset line, open drain
  input  wire logic                 RST_LINE_IN,
  output logic                      RST_LINE_OUT,
  output logic                      RST_LINE_OE_OUT
);

  typedef enum logic [2:0] {
    S_PWR_FAIL,
    S_PWR_HOLD,
    S_IDLE,
    S_DEBOUNCE,
    S_WAIT_REL,
    S_PULSE
  } sup_state_t;

  // Synchronisers and edge history
  logic [GRADE_CNT-1:0] fail_s1_reg;
  logic [GRADE_CNT-1:0] fail_s2_reg;
  logic                 line_s1_reg;
  logic                 line_s2_reg;
  logic                 line_prev_reg;

  // Comparators reset to fail, so power-on always sees a full hold
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      fail_s1_reg <= FAIL_IDLE;
      fail_s2_reg <= FAIL_IDLE;
    end else begin
      fail_s1_reg <= SUPPLY_FAIL_IN;
      fail_s2_reg <= fail_s1_reg;
    end
  end

  // Wire history resets high; the wire is low then, but the sequencer is
  // still in the supply-fail state when that first falling edge is seen, and ignores it
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      line_s1_reg   <= LINE_IDLE;
      line_s2_reg   <= LINE_IDLE;
      line_prev_reg <= LINE_IDLE;
    end else begin
      line_s1_reg   <= RST_LINE_IN;
      line_s2_reg   <= line_s1_reg;
      line_prev_reg <= line_s2_reg;
    end
  end

  // Edge of the synchronised wire towards to_lvl; both detectors share
  // it so the press and release edges cannot drift apart
  function automatic logic wire_edge(input logic old_lvl,
                                     input logic new_lvl,
                                     input logic to_lvl);
    return (old_lvl != to_lvl) && (new_lvl == to_lvl);
  endfunction

  logic supply_fail;
  logic line_fall;
  logic line_rise;

  assign supply_fail = fail_s2_reg[SUPPLY_TRIP_THRESHOLD];
  assign line_fall   = wire_edge(line_prev_reg, line_s2_reg, ~LINE_IDLE);
  assign line_rise   = wire_edge(line_prev_reg, line_s2_reg, LINE_IDLE);

  // States in which the supervisor holds the shared wire low
  function automatic logic pulls_line(input sup_state_t st);
    logic pull;
    pull = 1'b0;
    unique case (st)
      S_PWR_FAIL: begin
        pull = 1'b1;
      end
      S_PWR_HOLD: begin
        pull = 1'b1;
      end
      S_IDLE: begin
        pull = 1'b0;
      end
      S_DEBOUNCE: begin
        pull = 1'b1;
      end
      S_WAIT_REL: begin
        pull = 1'b0;
      end
      S_PULSE: begin
        pull = 1'b1;
      end
      // Unused codes pull as well, the safe side for a reset line
      default: begin
        pull = 1'b1;
      end
    endcase
    return pull;
  endfunction

  // Sequencer
  sup_state_t state_reg;
  sup_state_t state_next;
  logic       oe_reg;
  logic       oe_next;
  logic       timer_start;
  logic       timer_done;

  // Timer start is a one-cycle strobe on entry to each timed state
  always_comb begin
    state_next  = state_reg;
    timer_start = 1'b0;
    if (supply_fail) begin
      state_next = S_PWR_FAIL;
    end else begin
      unique case (state_reg)
        S_PWR_FAIL: begin
          state_next  = S_PWR_HOLD;
          timer_start = 1'b1;
        end
        S_PWR_HOLD: begin
          if (timer_done) begin
            state_next = S_IDLE;
          end
        end
        // Watch for press
        // A button held across a hold is only seen once pressed again
        S_IDLE: begin
          if (line_fall) begin
            state_next  = S_DEBOUNCE;
            timer_start = 1'b1;
          end
        end
        S_DEBOUNCE: begin
          if (timer_done) begin
            state_next = S_WAIT_REL;
          end
        end
        // Wait for release
        // A wire already high after debounce rises here, which counts
        S_WAIT_REL: begin
          if (line_rise) begin
            state_next  = S_PULSE;
            timer_start = 1'b1;
          end
        end
        S_PULSE: begin
          if (timer_done) begin
            state_next = S_IDLE;
          end
        end
        // Illegal code: restart from the safe supply-fail state
        default: begin
          state_next = S_PWR_FAIL;
        end
      endcase
    end
    oe_next = pulls_line(state_next);
  end

  // Reset enters the supply-fail state so power-on gets a full hold
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_reg <= S_PWR_FAIL;
      oe_reg    <= 1'b1;
    end else begin
      state_reg <= state_next;
      oe_reg    <= oe_next;
    end
  end

  // One timer serves all three intervals; each start restarts it
  // Shared interval timer
  interval_timer #(
    .TERM_COUNT (HOLD_CYCLES_P)
  ) u_timer (
    .clk_in   (CLK_IN),
    .nrst_in  (NRST_IN),
    .start_in (timer_start),
    .done_out (timer_done)
  );

  // Output data is a constant low; only the enable moves
  logic line_out_reg;

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      line_out_reg <= 1'b0;
    end else begin
      line_out_reg <= 1'b0;
    end
  end

  assign RST_LINE_OUT    = line_out_reg;
  assign RST_LINE_OE_OUT = oe_reg;

endmodule

//--- supervisor_chk.sv
`timescale 1ns/100ps
module supervisor_chk
  import supervisor_pkg::*;
#(parameter logic [CNT_W-1:0] HOLD_CYCLES_P = HOLD_CYCLES,
  parameter trip_grade_t      GRADE_P       = GRADE_10PCT) (
  // Clock, reset
  input wire logic       CLK_IN,
  input wire logic       NRST_IN,
  // Pins
  input wire logic [2:0] SUPPLY_FAIL_IN,
  input wire logic       RST_LINE_IN,
  input wire logic       RST_LINE_OUT,
  input wire logic       RST_LINE_OE_OUT
);
  wire fl = SUPPLY_FAIL_IN[GRADE_P]; // Grade the design was built for
  wire oe = RST_LINE_OE_OUT;
  wire ln = RST_LINE_IN;
  int hi_reg, hi_next;
  always_comb hi_next = oe ? hi_reg + 1 : 0;
  always_ff @(posedge CLK_IN or negedge NRST_IN)
    if (!NRST_IN) hi_reg <= 0;
    else hi_reg <= hi_next;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  sequence held; $fell(oe) && !ln; endsequence
  a_line_data: assert property (!RST_LINE_OUT)
    else $error("line data");
  a_fail_pulls: assert property (fl [*3] |=> oe)
    else $error("fail missed");
  a_start_held: assert property ($rose(NRST_IN) |-> oe [*3])
    else $error("start hold");
  a_hold_min: assert property ($fell(oe) |-> hi_reg >= HOLD_CYCLES_P)
    else $error("too short");
  a_wait_rel: assert property (held |=> !oe [*3])
    else $error("no wait");
  a_press_grab: assert property ($fell(ln) && !oe |-> ##[1:5] oe)
    else $error("press lost");
  a_rel_pulse: assert property (held ##[1:8] $rose(ln) |-> ##[1:6] oe)
    else $error("no pulse");
  a_grade_pick: assert property ((!oe && ln && !fl) [*6] |=> !oe)
    else $error("bad grade");
endmodule
bind reset_supervisor supervisor_chk #(.HOLD_CYCLES_P(HOLD_CYCLES_P),
  .GRADE_P(SUPPLY_TRIP_THRESHOLD)) chk (
  .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .SUPPLY_FAIL_IN(SUPPLY_FAIL_IN),
  .RST_LINE_IN(RST_LINE_IN), .RST_LINE_OUT(RST_LINE_OUT),
  .RST_LINE_OE_OUT(RST_LINE_OE_OUT));

//--- button_model.sv
`timescale 1ns/100ps
module button_model (
  // Contact, device driver data and enable
  input  wire logic closed_in,
  input  wire logic data_in,
  input  wire logic oe_in,
  // Wire
  output logic      line_out
);
  // pull-up; the contact or the driven level pulls it down
  assign line_out = !(closed_in || (oe_in && !data_in));
endmodule

//--- reset_supervisor_test.sv
`timescale 1ns/100ps
module reset_supervisor_test;
  logic clk = 1'b0, nrst = 1'b0, btn = 1'b0, ln, oe, dat;
  logic [2:0] sf = 3'h0;
  int err_count = 0, check_count = 0;
  always #2.5 clk = ~clk;
  reset_supervisor #(.HOLD_CYCLES_P(27'h0000014)) DUT (.CLK_IN(clk),
    .NRST_IN(nrst), .SUPPLY_FAIL_IN(sf), .RST_LINE_IN(ln),
    .RST_LINE_OUT(dat), .RST_LINE_OE_OUT(oe));
  button_model pb (.closed_in(btn), .data_in(dat), .oe_in(oe),
    .line_out(ln));
  task final_report;
    $display("checks %0d bad %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(string s, logic e, logic g);
    check_count++;
    if (e !== g) begin
      err_count++;
      $display("MISMATCH %s exp %b got %b", s, e, g);
    end
  endtask
  task cy(int n);
    repeat (n) @(negedge clk);
  endtask
  task wt(logic v);
    for (int i = 0; i < 40 && oe !== v; i++)
      cy(1);
    chk("oe wait", v, oe);
    if (oe !== v)
      final_report();
  endtask
  task t_sag;
    wt(1'b0);
    sf = 3'h1;
    cy(8);
    chk("oe grade", 1'b0, oe);
    sf = 3'h7;
    cy(4);
    chk("oe fail", 1'b1, oe);
    sf = 3'h0;
    cy(20);
    chk("oe hold", 1'b1, oe);
    wt(1'b0);
    $display("sag done");
  endtask
  task t_press;
    cy(6);
    btn = 1'b1;
    cy(6);
    chk("oe press", 1'b1, oe);
    chk("line data", 1'b0, dat);
    wt(1'b0);
    cy(2);
    chk("line held", 1'b0, ln);
    chk("oe waits", 1'b0, oe);
    btn = 1'b0;
    cy(6);
    chk("oe pulse", 1'b1, oe);
    wt(1'b0);
    $display("press done");
  endtask
  initial begin
    cy(6);
    nrst = 1'b1;
    t_sag();
    t_press();
    final_report();
  end
endmodule
